// >>> verilog/prs_map.svh
// Clock rate and timing constants for the panel reset sequencer.
`ifndef PRS_MAP_SVH
`define PRS_MAP_SVH
`define PRS_CLK_MHZ 125
`define PRS_REJECT_US 5
`define PRS_ACCEPT_US 9
`define PRS_REJECT_CYC (`PRS_REJECT_US * `PRS_CLK_MHZ)
`define PRS_ACCEPT_CYC (`PRS_ACCEPT_US * `PRS_CLK_MHZ)
`define PRS_LOAD_START_MS 5
`define PRS_BLANK_MAX_MS 120
`define PRS_CANCEL_AWAKE_MS 35
`define PRS_CANCEL_SLEEP_MS 150
`define PRS_SUPPLY_MIN_MS 2
`define PRS_SUPPLY_TYP_MS 5
`define PRS_HOLD_MIN_MS 4
`define PRS_HOLD_TYP_MS 10
`define PRS_CMD_SLEEP_MS 10
`define PRS_MS_CYC(ms) ((ms) * 1000 * `PRS_CLK_MHZ)
`endif

// >>> verilog/prs_pkg.sv
// State types for the panel reset sequencer, one type for each end.
package prs_pkg;
  typedef enum logic [4:0] {
    PRS_RUN = 5'h01,
    PRS_RESET = 5'h02,
    PRS_BLANK = 5'h04,
    PRS_LOAD = 5'h08,
    PRS_IDLE = 5'h10
  } prs_dev_e;
  typedef enum logic [5:0] {
    PRS_H_OFF = 6'h01,
    PRS_H_SUP1 = 6'h02,
    PRS_H_SUP2 = 6'h04,
    PRS_H_HOLD = 6'h08,
    PRS_H_CANCEL = 6'h10,
    PRS_H_READY = 6'h20
  } prs_host_e;
endpackage

// >>> verilog/prs_link_if.sv
// Interface joining the host sequencer and the panel reset logic.
`timescale 1ns/10ps
interface prs_link_if;
  logic panel_reset_n;
  logic supply_io_en;
  logic supply_analog_en;
  modport host (
    output panel_reset_n,
    output supply_io_en,
    output supply_analog_en
  );
  modport panel (
    input panel_reset_n,
    input supply_io_en,
    input supply_analog_en
  );
endinterface

// >>> verilog/prs_panel.sv
// Panel end: reset filter, blanking and settings reload.
`timescale 1ns/10ps
`include "prs_map.svh"
module prs_panel #(
  parameter int REJECT_CYC = `PRS_REJECT_CYC,
  parameter int ACCEPT_CYC = `PRS_ACCEPT_CYC,
  parameter int LOAD_START_CYC = `PRS_MS_CYC(`PRS_LOAD_START_MS),
  parameter int BLANK_CYC = `PRS_MS_CYC(`PRS_BLANK_MAX_MS),
  parameter int LOAD_CYC = 64
) (
  input wire logic mclk,
  input wire logic rst,
  prs_link_if.panel link,
  input wire logic sleep_out,
  output logic in_reset,
  output logic display_blank,
  output logic load_active,
  output logic load_done,
  output logic ready
);
  // Registers with their next values, then named decode wires.
  prs_pkg::prs_dev_e state_reg;
  prs_pkg::prs_dev_e state_next;
  logic sync1_reg;
  logic sync2_reg;
  logic [31:0] low_cnt_reg;
  logic [31:0] low_cnt_next;
  logic [31:0] high_cnt_reg;
  logic [31:0] high_cnt_next;
  logic [31:0] tmr_reg;
  logic [31:0] tmr_next;
  logic filt_reg;
  logic filt_next;
  logic load_done_next;
  logic pin_low;
  logic low_full;
  logic high_full;
  logic accepted;
  logic released;
  logic tmr_clr;
  logic blank_end;
  logic load_begin;
  logic load_end;
  logic load_finish;
  logic idle_hold;

  // Two flops bring the asynchronous reset pin onto mclk. Only the
  // second flop is read, so a metastable first stage never reaches
  // the counters. Both start high so that a reset of this block alone
  // is not mistaken for the start of a pin pulse.
  // Pin synchroniser.
  always_ff @(posedge mclk) begin
    if (rst) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
    end else begin
      sync1_reg <= link.panel_reset_n;
      sync2_reg <= sync1_reg;
    end
  end

  // Low and high run lengths of the synchronised pin. They saturate
  // instead of wrapping, so a pin held for a very long time never
  // reads as a short pulse.
  // Low and high duration counters.
  assign pin_low = !sync2_reg;
  assign low_full = (low_cnt_reg == 32'hffffffff);
  assign high_full = (high_cnt_reg == 32'hffffffff);
  assign low_cnt_next = !pin_low ? 32'h0 :
                        low_full ? low_cnt_reg : low_cnt_reg + 32'h1;
  assign high_cnt_next = pin_low ? 32'h0 :
                         high_full ? high_cnt_reg : high_cnt_reg + 32'h1;

  // Run length registers.
  always_ff @(posedge mclk) begin
    if (rst) begin
      low_cnt_reg <= 32'h0;
      high_cnt_reg <= 32'h0;
    end else begin
      low_cnt_reg <= low_cnt_next;
      high_cnt_reg <= high_cnt_next;
    end
  end

  // A low is accepted once it reaches the 9us count. Lows in the
  // 5us..9us band are rejected as well, which the band permits; the
  // price is that a marginal pulse never resets the panel.
  // Width threshold.
  assign accepted = pin_low && (low_cnt_reg >= 32'(ACCEPT_CYC));
  // Inside a reset, a high shorter than the spike limit is ignored.
  // Spike rejection inside pulse.
  assign released = !pin_low && (high_cnt_reg >= 32'(REJECT_CYC));
  // An accepted low sets the filtered level; it wins over a release.
  assign filt_next = accepted ? 1'b1 : released ? 1'b0 : filt_reg;

  // Filtered reset level.
  always_ff @(posedge mclk) begin
    if (rst) begin
      filt_reg <= 1'b0;
    end else begin
      filt_reg <= filt_next;
    end
  end

  // Timer thresholds. The reload wait is shortened by the release
  // filter delay (spike limit plus synchroniser and register stages),
  // so the reload starts within the allowed time of the pin edge and
  // not of the filtered level.
  assign blank_end = (tmr_reg >= 32'(BLANK_CYC - 1));
  // Reload start measured from pin edge.
  assign load_begin = (tmr_reg >= 32'(LOAD_START_CYC - REJECT_CYC - 5));
  assign load_end = (tmr_reg >= 32'(LOAD_CYC - 1));
  // Idle holds its timer at zero while the pin is low or the reset is
  // still filtered, so a pin held low from power-up never starts a
  // reload before the reset is recognised. A rejected glitch in idle
  // restarts the wait, which delays the reload a little.
  assign idle_hold = filt_reg || pin_low;

  // Sequence: reset entry, blanking, idle in default, reload. The
  // blanking sequence ends early once reset is released, because the
  // reload must begin soon after the pin edge; the display output
  // stays blank until the reload is done either way.
  always_comb begin
    state_next = state_reg;
    tmr_clr = 1'b0;
    unique case (state_reg)
      prs_pkg::PRS_RUN: begin
        if (filt_reg) begin
          tmr_clr = 1'b1;
          state_next = prs_pkg::PRS_RESET;
        end
      end
      prs_pkg::PRS_RESET: begin
        tmr_clr = 1'b1;
        state_next = sleep_out ? prs_pkg::PRS_BLANK : prs_pkg::PRS_IDLE;
      end
      prs_pkg::PRS_BLANK: begin
        if (blank_end || !filt_reg) begin
          tmr_clr = 1'b1;
          state_next = prs_pkg::PRS_IDLE;
        end
      end
      prs_pkg::PRS_IDLE: begin
        if (idle_hold) begin
          tmr_clr = 1'b1;
        end else if (load_begin) begin
          tmr_clr = 1'b1;
          state_next = prs_pkg::PRS_LOAD;
        end
      end
      prs_pkg::PRS_LOAD: begin
        if (filt_reg) begin
          tmr_clr = 1'b1;
          state_next = prs_pkg::PRS_IDLE;
        end else if (load_end) begin
          state_next = prs_pkg::PRS_RUN;
        end
      end
      default: begin
        tmr_clr = 1'b1;
        state_next = prs_pkg::PRS_IDLE;
      end
    endcase
  end

  // Timer and reload-done flag. The flag is set as the reload ends and
  // cleared by the next filtered reset; the set has priority, though a
  // filtered reset already sends the reload back to idle.
  assign tmr_next = tmr_clr ? 32'h0 : tmr_reg + 32'h1;
  assign load_finish = (state_reg == prs_pkg::PRS_LOAD) &&
                       (state_next == prs_pkg::PRS_RUN);
  assign load_done_next = load_finish ? 1'b1 :
                          filt_reg ? 1'b0 : load_done;

  // State, timer and flag registers.
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg <= prs_pkg::PRS_IDLE;
      tmr_reg <= 32'h0;
      load_done <= 1'b0;
    end else begin
      state_reg <= state_next;
      tmr_reg <= tmr_next;
      load_done <= load_done_next;
    end
  end

  // Status outputs. The filtered level is folded in so that the panel
  // reads blank and not ready from the very cycle the reset is taken,
  // one cycle before the state leaves run.
  // Blank while in reset.
  assign in_reset = filt_reg;
  assign display_blank = (state_reg != prs_pkg::PRS_RUN) || filt_reg;
  assign load_active = (state_reg == prs_pkg::PRS_LOAD);
  assign ready = (state_reg == prs_pkg::PRS_RUN) && !filt_reg;
endmodule

// >>> verilog/prs_host.sv
// Host end: supply ordering, reset hold and release waits.
`timescale 1ns/10ps
`include "prs_map.svh"
module prs_host #(
  parameter int SUPPLY_CYC = `PRS_MS_CYC(`PRS_SUPPLY_TYP_MS),
  parameter int HOLD_CYC = `PRS_MS_CYC(`PRS_HOLD_TYP_MS),
  parameter int CANCEL_AWAKE_CYC = `PRS_MS_CYC(`PRS_CANCEL_AWAKE_MS),
  parameter int CANCEL_SLEEP_CYC = `PRS_MS_CYC(`PRS_CANCEL_SLEEP_MS),
  parameter int CMD_SLEEP_CYC = `PRS_MS_CYC(`PRS_CMD_SLEEP_MS)
) (
  input wire logic mclk,
  input wire logic rst,
  prs_link_if.host link,
  input wire logic power_up,
  input wire logic reset_req,
  input wire logic sleep_in,
  output logic cmd_ok
);
  prs_pkg::prs_host_e state_reg;
  prs_pkg::prs_host_e state_next;
  logic [31:0] tmr_reg;
  logic tmr_clr;
  logic [31:0] wait_cyc;

  // Release wait: the longer of the cancel time and the sleep-in
  // command delay applies.
  // Cancel time.
  assign wait_cyc = sleep_in ? 32'(CANCEL_SLEEP_CYC) :
                    32'(CANCEL_AWAKE_CYC);

  always_comb begin
    state_next = state_reg;
    tmr_clr = 1'b0;
    unique case (state_reg)
      prs_pkg::PRS_H_OFF: begin
        tmr_clr = 1'b1;
        if (power_up) begin
          state_next = prs_pkg::PRS_H_SUP1;
        end
      end
      prs_pkg::PRS_H_SUP1: begin
        if (tmr_reg >= 32'(SUPPLY_CYC - 1)) begin
          tmr_clr = 1'b1;
          state_next = prs_pkg::PRS_H_SUP2;
        end
      end
      prs_pkg::PRS_H_SUP2: begin
        tmr_clr = 1'b1;
        state_next = prs_pkg::PRS_H_HOLD;
      end
      prs_pkg::PRS_H_HOLD: begin
        if (tmr_reg >= 32'(HOLD_CYC - 1)) begin
          tmr_clr = 1'b1;
          state_next = prs_pkg::PRS_H_CANCEL;
        end
      end
      prs_pkg::PRS_H_CANCEL: begin
        if (tmr_reg >= wait_cyc - 32'h1 &&
            tmr_reg >= 32'(CMD_SLEEP_CYC - 1)) begin
          state_next = prs_pkg::PRS_H_READY;
        end
      end
      prs_pkg::PRS_H_READY: begin
        if (!power_up) begin
          state_next = prs_pkg::PRS_H_OFF;
        end else if (reset_req) begin
          tmr_clr = 1'b1;
          state_next = prs_pkg::PRS_H_HOLD;
        end
      end
      default: begin
        state_next = prs_pkg::PRS_H_OFF;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg <= prs_pkg::PRS_H_OFF;
      tmr_reg <= 32'h0;
    end else begin
      state_reg <= state_next;
      tmr_reg <= tmr_clr ? 32'h0 : tmr_reg + 32'h1;
    end
  end

  // Reset is held low through every state up to the cancel wait.
  always_ff @(posedge mclk) begin
    if (rst) begin
      link.panel_reset_n <= 1'b0;
      link.supply_io_en <= 1'b0;
      link.supply_analog_en <= 1'b0;
      cmd_ok <= 1'b0;
    end else begin
      link.supply_io_en <= (state_next != prs_pkg::PRS_H_OFF);
      link.supply_analog_en <= (state_next != prs_pkg::PRS_H_OFF) &&
                               (state_next != prs_pkg::PRS_H_SUP1);
      link.panel_reset_n <= (state_next == prs_pkg::PRS_H_CANCEL) ||
                            (state_next == prs_pkg::PRS_H_READY);
      cmd_ok <= (state_next == prs_pkg::PRS_H_READY);
    end
  end
endmodule

// >>> tb/prs_link_checker.sv
// Checker for the host-to-panel link and the panel status.
`timescale 1ns/10ps
module prs_link_checker (
  input wire logic mclk,
  input wire logic rst,
  input wire logic panel_reset_n,
  input wire logic supply_io_en,
  input wire logic supply_analog_en,
  input wire logic in_reset,
  input wire logic display_blank,
  input wire logic load_active,
  input wire logic ready,
  input wire logic cmd_ok
);
  logic [7:0] lo_reg;
  logic [7:0] hi_reg;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Run lengths of each pin level; they saturate so long waits stay valid.
  always_ff @(posedge mclk) begin
    lo_reg <= (rst || panel_reset_n) ? 8'h00 : lo_reg + {7'h00, ~&lo_reg};
    hi_reg <= (rst || !panel_reset_n) ? 8'h00 : hi_reg + {7'h00, ~&hi_reg};
  end
  property p_short; $fell(panel_reset_n) && !in_reset |-> !in_reset[*8];
  endproperty
  property p_long; lo_reg >= 8'h10 |-> in_reset; endproperty
  property p_keep; $rose(panel_reset_n) && in_reset |-> in_reset[*5];
  endproperty
  property p_free; hi_reg >= 8'h0c |-> !in_reset; endproperty
  property p_blank; in_reset |-> display_blank && !ready; endproperty
  property p_load; $rose(panel_reset_n) |-> ##[1:20] load_active; endproperty
  property p_supply;
    $rose(supply_analog_en) |-> $past(supply_io_en, 8) && !panel_reset_n;
  endproperty
  property p_hold; $rose(panel_reset_n) |-> lo_reg >= 8'h12; endproperty
  property p_cmd; $rose(cmd_ok) |-> panel_reset_n && hi_reg >= 8'h26;
  endproperty
  a_short: assert property (p_short)
    else $error("reset taken too early");
  a_long: assert property (p_long)
    else $error("long low not taken");
  a_keep: assert property (p_keep)
    else $error("short high broke reset");
  a_free: assert property (p_free)
    else $error("reset not left");
  a_blank: assert property (p_blank)
    else $error("not blank in reset");
  a_load: assert property (p_load)
    else $error("reload late");
  a_supply: assert property (p_supply)
    else $error("supply spacing");
  a_hold: assert property (p_hold)
    else $error("reset hold short");
  a_cmd: assert property (p_cmd)
    else $error("command too early");
  // The main flows: a reset taken, a reload ended, commands allowed.
  cover property ($rose(in_reset));
  cover property ($fell(load_active));
  cover property ($rose(cmd_ok));
endmodule

// >>> tb/tb_panel_reset_sequencer.sv
// Testbench: host and panel joined, plus a spare panel for pin glitches.
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
  bad_count++; $display("CHECK FAILED %0t value %b", $time, a); end end
`define WT(c) begin n = 0; while ((c) !== 1'b1 && n < 400) begin \
  @(negedge mclk); n++; end if (n >= 400) begin \
  bad_count++; summarize(); end end
module tb_panel_reset_sequencer;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic power_up = 1'b0;
  logic reset_req = 1'b0;
  logic sleep_in = 1'b0;
  logic sleep_out = 1'b1;
  logic in_reset, display_blank, load_active, load_done, ready, cmd_ok;
  logic in_reset_b, load_done_b, ready_b;
  int bad_count = 0;
  int total_checks = 0;
  int n;
  prs_link_if link ();
  prs_link_if link_b ();
  // Timing counts shortened so that the run stays short.
  localparam int T_SUPPLY = 10;
  localparam int T_HOLD = 20;
  localparam int T_AWAKE = 40;
  localparam int T_SLEEP = 60;
  localparam int T_CMD = 15;
  localparam int T_REJECT = 5;
  localparam int T_ACCEPT = 9;
  localparam int T_LOAD_START = 20;
  localparam int T_BLANK = 30;
  localparam int T_LOAD = 8;
  // Clock at 125 MHz.
  always #4 mclk = ~mclk;
  prs_host #(.SUPPLY_CYC(T_SUPPLY), .HOLD_CYC(T_HOLD),
    .CANCEL_AWAKE_CYC(T_AWAKE), .CANCEL_SLEEP_CYC(T_SLEEP),
    .CMD_SLEEP_CYC(T_CMD)) u_prs_host (.mclk, .rst, .link(link),
    .power_up, .reset_req, .sleep_in, .cmd_ok);
  prs_panel #(.REJECT_CYC(T_REJECT), .ACCEPT_CYC(T_ACCEPT),
    .LOAD_START_CYC(T_LOAD_START), .BLANK_CYC(T_BLANK), .LOAD_CYC(T_LOAD))
    u_prs_panel (.mclk, .rst, .link(link), .sleep_out, .in_reset,
    .display_blank, .load_active, .load_done, .ready);
  // The spare panel's pin is driven here, so it can be broken on purpose.
  prs_panel #(.REJECT_CYC(T_REJECT), .ACCEPT_CYC(T_ACCEPT),
    .LOAD_START_CYC(T_LOAD_START), .BLANK_CYC(T_BLANK), .LOAD_CYC(T_LOAD))
    u_prs_panel_b (.mclk, .rst,
    .link(link_b), .sleep_out, .in_reset(in_reset_b), .display_blank(),
    .load_active(), .load_done(load_done_b), .ready(ready_b));
  prs_link_checker u_prs_link_checker (.mclk, .rst,
    .panel_reset_n(link.panel_reset_n), .supply_io_en(link.supply_io_en),
    .supply_analog_en(link.supply_analog_en), .in_reset, .display_blank,
    .load_active, .ready, .cmd_ok);
  task automatic summarize;
    if (bad_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Low pulse on the spare pin; a taken reset leaves no reload 20 later.
  task automatic spike(input int lo, input logic kept);
    link_b.panel_reset_n = 1'b0;
    repeat (lo) @(negedge mclk);
    link_b.panel_reset_n = 1'b1;
    repeat (20) @(negedge mclk);
    `CHK(load_done_b, kept)
    `CHK(ready_b, kept)
  endtask
  // A host reset in mid-run; sleep_in picks the longer release wait.
  task automatic host_reset(input int min);
    reset_req = 1'b1;
    @(negedge mclk);
    reset_req = 1'b0;
    `WT(in_reset)
    `CHK(display_blank, 1'b1)
    `CHK(cmd_ok, 1'b0)
    `WT(link.panel_reset_n)
    `WT(cmd_ok)
    `CHK(n >= min, 1'b1)
    `CHK(ready, 1'b1)
    `CHK(load_done, 1'b1)
  endtask
  initial begin
    link_b.panel_reset_n = 1'b1;
    link_b.supply_io_en = 1'b1;
    link_b.supply_analog_en = 1'b1;
    repeat (4) @(negedge mclk);
    rst = 1'b0;
    power_up = 1'b1;
    `WT(link.panel_reset_n)
    `WT(cmd_ok)
    `CHK(n >= 38, 1'b1)
    `CHK(display_blank, 1'b0)
    `CHK(load_done, 1'b1)
    `WT(ready_b)
    spike(4, 1'b1);
    spike(7, 1'b1);
    // A short high inside a taken reset must not end it.
    link_b.panel_reset_n = 1'b0;
    repeat (15) @(negedge mclk);
    `CHK(in_reset_b, 1'b1)
    link_b.panel_reset_n = 1'b1;
    repeat (3) @(negedge mclk);
    link_b.panel_reset_n = 1'b0;
    repeat (8) @(negedge mclk);
    `CHK(in_reset_b, 1'b1)
    spike(1, 1'b0);
    `WT(ready_b)
    `CHK(load_done_b, 1'b1)
    sleep_in = 1'b1;
    host_reset(58);
    sleep_out = 1'b0;
    host_reset(58);
    sleep_in = 1'b0;
    host_reset(38);
    summarize();
  end
endmodule
